//--- dpr_consts.svh
// constants for the dual pipe rename and forward block
// assumes inclusion by the package and by the design module
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH
`define DPR_NPHYS    32
`define DPR_NLOG     8
`define DPR_PW       5
`define DPR_LW       3
`define DPR_FREE_RST 32'hffffff00
`define DPR_BYP_CYC  1
`endif

//--- dpr_pkg.sv
// types for the dual pipe rename and forward block
// assumes dpr_consts.svh is on the include path
`include "dpr_consts.svh"
package dpr_pkg;
  typedef logic [`DPR_PW-1:0] dpr_phys_t;
  typedef logic [`DPR_LW-1:0] dpr_log_t;

  // one decoded instruction as it leaves the decode stage
  typedef struct packed {
    logic      valid;
    logic      rd_a;
    dpr_log_t  src_a;
    logic      rd_b;
    dpr_log_t  src_b;
    logic      wr;
    dpr_log_t  dst;
    logic      move;
    logic      mem_rd;
    logic      mem_wr;
    logic [1:0] size;
  } dpr_inst_t;

  // renamed pair handed to the address stage
  typedef struct packed {
    logic      valid;
    dpr_phys_t x_dst;
    dpr_phys_t x_a;
    dpr_phys_t x_b;
    dpr_phys_t y_dst;
    dpr_phys_t y_a;
    dpr_phys_t y_b;
    logic      opnd_fwd;
    logic      rslt_fwd;
    logic      bypass;
    logic      interlock;
  } dpr_issue_t;

  typedef enum logic [2:0] {
    DPR_RUN  = 3'h1,
    DPR_BYP  = 3'h2,
    DPR_WAIT = 3'h4
  } dpr_state_t;
endpackage : dpr_pkg

//--- dpr_rename.sv
// rename, forward and bypass control for the paired integer pipes
// assumes decode, address stage and retire logic share CLK
//
// Operation
// (RULE1) each result gets a freshly allocated physical register
// (RULE2) Y writing a register X reads does not stall Y
// (RULE3) both writing one register: Y proceeds without stall
// (RULE4) after paired writes, later reads map to Y's register
// (RULE5) renamed pair may finish together or out of order
// (RULE6) read after write solved by operand or result forwarding
// (RULE7) X move feeds its one read to both instructions
// (RULE8) operand forwarding only for move-type X, register or memory
// (RULE9) operand forwarding only when operand sizes match
// (RULE10) X result stored to both destinations at once
// (RULE11) result forwarding only when Y is a move
// (RULE12) computed value goes straight to memory, saving a clock
// (RULE13) X store data bypassed to Y load, no memory read
// (RULE14) bypass only for cacheable locations
// (RULE15) bypass stalls Y for at most one clock
// (RULE16) pool of 32 physical registers for 8 logical ones
// (RULE17) exceptions and writes leave in program order
// (RULE18) unsolved dependency stalls Y by interlock
// (RULE19) register freed only when nothing references it
// (RULE20) X is the earlier instruction of the pair
`include "dpr_consts.svh"
module dpr_rename (
  input  wire logic               CLK,
  input  wire logic               RSTN,
  input  wire dpr_pkg::dpr_inst_t PAIR_X,
  input  wire dpr_pkg::dpr_inst_t PAIR_Y,
  input  wire logic               SAME_ADDR,
  input  wire logic               CACHEABLE,
  input  wire logic               X_DONE,
  input  wire logic [1:0]         FREE_EN,
  input  wire dpr_pkg::dpr_phys_t FREE_A,
  input  wire dpr_pkg::dpr_phys_t FREE_B,
  output logic                    PAIR_READY,
  output dpr_pkg::dpr_issue_t     ISSUE,
  output dpr_pkg::dpr_phys_t      X_OLD,
  output dpr_pkg::dpr_phys_t      Y_OLD,
  output logic                    Y_STALL,
  output logic                    Y_COMMIT_OK
);
  dpr_pkg::dpr_phys_t   map_ff [`DPR_NLOG];
  logic [`DPR_NPHYS-1:0] free_ff;
  logic [`DPR_NPHYS-1:0] nxt_free;
  dpr_pkg::dpr_state_t  st_ff;
  dpr_pkg::dpr_state_t  nxt_st;
  logic                 x_pend_ff;
  logic                 nxt_x_pend;
  dpr_pkg::dpr_issue_t  nxt_issue;

  // checks below all sample on CLK and sleep during reset
  default clocking dpr_cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // lowest free register other than skip
  function automatic dpr_pkg::dpr_phys_t pick(
      input logic [`DPR_NPHYS-1:0] v, input logic use_skip,
      input dpr_pkg::dpr_phys_t skip);
    dpr_pkg::dpr_phys_t r;
    r = '0;
    for (int i = `DPR_NPHYS - 1; i >= 0; i--) begin
      if (v[i] && !(use_skip && skip == i[`DPR_PW-1:0])) begin
        r = i[`DPR_PW-1:0];
      end
    end
    return r;
  endfunction : pick

  wire accept = PAIR_READY & PAIR_X.valid & (st_ff == dpr_pkg::DPR_RUN);
  wire x_w    = PAIR_X.wr;
  wire y_w    = PAIR_Y.valid & PAIR_Y.wr;

  // (RULE16) allocation draws from the 32 entry pool
  wire dpr_pkg::dpr_phys_t px = pick(free_ff, 1'b0, '0);
  wire dpr_pkg::dpr_phys_t py = pick(free_ff, x_w, px);

  // (RULE20) X earlier: only Y can depend on X
  wire raw_a   = PAIR_Y.valid & PAIR_Y.rd_a & x_w
                 & (PAIR_Y.src_a == PAIR_X.dst);
  wire raw_b   = PAIR_Y.valid & PAIR_Y.rd_b & x_w
                 & (PAIR_Y.src_b == PAIR_X.dst);
  wire raw     = raw_a | raw_b;
  wire mem_raw = PAIR_Y.valid & PAIR_X.mem_wr & PAIR_Y.mem_rd & SAME_ADDR;

  // (RULE8) (RULE9) move-type X with matching size
  wire opnd_ok = raw & PAIR_X.move & (PAIR_X.size == PAIR_Y.size);
  // (RULE11) Y must be a move
  wire rslt_ok = raw & ~opnd_ok & PAIR_Y.move;
  // (RULE14) bypass only for cacheable data
  wire byp_ok  = mem_raw & CACHEABLE;
  // (RULE18) (RULE6) anything unsolved interlocks
  wire ilock   = (raw & ~opnd_ok & ~rslt_ok) | (mem_raw & ~CACHEABLE);

  // (RULE7) register move: Y reads X's source directly
  wire reg_src = PAIR_X.rd_a & ~PAIR_X.mem_rd;
  wire dpr_pkg::dpr_phys_t x_src_p = map_ff[PAIR_X.src_a];
  wire dpr_pkg::dpr_phys_t y_a_p =
       (raw_a & opnd_ok & reg_src) ? x_src_p :
       raw_a ? px : map_ff[PAIR_Y.src_a];
  wire dpr_pkg::dpr_phys_t y_b_p =
       (raw_b & opnd_ok & reg_src) ? x_src_p :
       raw_b ? px : map_ff[PAIR_Y.src_b];

  // (RULE2) (RULE3) Y renamed, no stall for WAR or WAW
  always_comb begin
    nxt_issue           = '0;
    nxt_issue.valid     = accept;
    nxt_issue.x_dst     = px;
    nxt_issue.x_a       = map_ff[PAIR_X.src_a];
    nxt_issue.x_b       = map_ff[PAIR_X.src_b];
    nxt_issue.y_dst     = y_w ? (x_w ? py : px) : '0;
    nxt_issue.y_a       = y_a_p;
    nxt_issue.y_b       = y_b_p;
    nxt_issue.opnd_fwd  = accept & opnd_ok;
    // (RULE10) (RULE12) X result also written to Y dest
    nxt_issue.rslt_fwd  = accept & rslt_ok;
    // (RULE13) store data handed to the load
    nxt_issue.bypass    = accept & byp_ok & ~ilock;
    nxt_issue.interlock = accept & ilock;
  end

  // (RULE1) (RULE19) claim on issue, release only on retire
  wire dpr_pkg::dpr_phys_t ydst = x_w ? py : px;
  always_comb begin
    nxt_free = free_ff;
    if (accept && x_w) begin
      nxt_free[px] = 1'b0;
    end
    if (accept && y_w) begin
      nxt_free[ydst] = 1'b0;
    end
    if (FREE_EN[0]) begin
      nxt_free[FREE_A] = 1'b1;
    end
    if (FREE_EN[1]) begin
      nxt_free[FREE_B] = 1'b1;
    end
  end

  // (RULE15) bypass holds Y one clock; interlock until X done
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      dpr_pkg::DPR_RUN: begin
        if (accept && ilock) begin
          nxt_st = dpr_pkg::DPR_WAIT;
        end else if (accept && byp_ok) begin
          nxt_st = dpr_pkg::DPR_BYP;
        end
      end
      dpr_pkg::DPR_BYP: nxt_st = dpr_pkg::DPR_RUN;
      dpr_pkg::DPR_WAIT: begin
        if (X_DONE) begin
          nxt_st = dpr_pkg::DPR_RUN;
        end
      end
      default: nxt_st = dpr_pkg::DPR_RUN;
    endcase
  end

  // (RULE17) Y may write or fault only once X has completed
  // (RULE5) completion itself is free to reorder
  assign nxt_x_pend = accept | (x_pend_ff & ~X_DONE);

  wire [`DPR_PW:0] nfree_cnt = (`DPR_PW+1)'($countones(nxt_free));
  wire pool_ok = nfree_cnt >= (`DPR_PW+1)'(2);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      free_ff <= `DPR_FREE_RST;
      st_ff   <= dpr_pkg::DPR_RUN;
      x_pend_ff <= 1'b0;
    end else begin
      free_ff <= nxt_free;
      st_ff   <= nxt_st;
      x_pend_ff <= nxt_x_pend;
    end
  end

  // (RULE4) Y mapping written last so later reads see Y
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < `DPR_NLOG; i++) begin
        map_ff[i] <= i[`DPR_PW-1:0];
      end
    end else if (accept) begin
      if (x_w) begin
        map_ff[PAIR_X.dst] <= px;
      end
      if (y_w) begin
        map_ff[PAIR_Y.dst] <= ydst;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ISSUE       <= '0;
      X_OLD       <= '0;
      Y_OLD       <= '0;
      PAIR_READY  <= 1'b1;
      Y_STALL     <= 1'b0;
      Y_COMMIT_OK <= 1'b1;
    end else begin
      ISSUE       <= nxt_issue;
      X_OLD       <= map_ff[PAIR_X.dst];
      Y_OLD       <= (x_w && PAIR_Y.dst == PAIR_X.dst) ? px
                     : map_ff[PAIR_Y.dst];
      PAIR_READY  <= pool_ok & (nxt_st == dpr_pkg::DPR_RUN);
      Y_STALL     <= nxt_st != dpr_pkg::DPR_RUN;
      Y_COMMIT_OK <= ~nxt_x_pend;
    end
  end

  sequence s_byp_issue;
    accept && byp_ok && !ilock;
  endsequence
  sequence s_one_stall;
    Y_STALL ##1 !Y_STALL;
  endsequence

  a_byp_one_clk: assert property // RULE15
    (s_byp_issue |=> s_one_stall)
    else $error("bypass stall not one");
  a_waw_no_stall: assert property // RULE3
    (accept && x_w && y_w && !raw && !mem_raw |=> !Y_STALL)
    else $error("WAW pair stalled");
  a_fresh_dst: assert property // RULE1
    (accept && x_w |-> free_ff[px])
    else $error("dst not free");
  a_pair_distinct: assert property // RULE3
    (accept && x_w && y_w |=> ISSUE.x_dst != ISSUE.y_dst)
    else $error("pair shares dst");
  a_later_map: assert property // RULE4
    (accept && x_w && y_w && PAIR_X.dst == PAIR_Y.dst
    |=> map_ff[$past(PAIR_Y.dst)] == ISSUE.y_dst)
    else $error("later read map wrong");
  a_opnd_size: assert property // RULE9
    (ISSUE.opnd_fwd |-> $past(PAIR_X.size) == $past(PAIR_Y.size))
    else $error("operand size mismatch");
  a_rslt_move: assert property // RULE11
    (accept && raw && !opnd_ok && !PAIR_Y.move |=> ISSUE.interlock)
    else $error("non-move not interlocked");
  a_uncached: assert property // RULE14
    (accept && mem_raw && !CACHEABLE |=> !ISSUE.bypass && Y_STALL)
    else $error("uncached bypassed");
  a_commit_order: assert property // RULE17
    (x_pend_ff && !X_DONE |=> !Y_COMMIT_OK)
    else $error("Y commit before X");
  a_wait_hold: assert property // RULE18
    (st_ff == dpr_pkg::DPR_WAIT && !X_DONE |=> Y_STALL)
    else $error("interlock released early");
endmodule : dpr_rename

//--- dpr_retire_model.sv
// retire side model: completes X after LAT cycles, returns old mappings
// assumes the bench holds wr bits of the pair while ISSUE is valid
module dpr_retire_model #(parameter int LAT = 3) (
  input  wire logic         CLK,
  input  wire logic         RSTN,
  input  wire logic         ISSUE_V,
  input  wire logic         X_WR,
  input  wire logic         Y_WR,
  input  wire dpr_pkg::dpr_phys_t X_OLD,
  input  wire dpr_pkg::dpr_phys_t Y_OLD,
  output logic              X_DONE,
  output logic [1:0]        FREE_EN,
  output dpr_pkg::dpr_phys_t FREE_A,
  output dpr_pkg::dpr_phys_t FREE_B
);
  int                 cnt;
  logic [1:0]         wr_ff;
  dpr_pkg::dpr_phys_t a_ff;
  dpr_pkg::dpr_phys_t b_ff;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt     <= 0;
      X_DONE  <= 1'b0;
      FREE_EN <= 2'h0;
      FREE_A  <= '0;
      FREE_B  <= '0;
    end else begin
      X_DONE  <= 1'b0;
      FREE_EN <= 2'h0;
      // idle numbers toggle so stale values never look valid
      FREE_A  <= ~FREE_A;
      FREE_B  <= ~FREE_B;
      // a new issue restarts the count, so a busy stream frees nothing
      if (ISSUE_V) begin
        cnt   <= LAT;
        wr_ff <= {Y_WR, X_WR};
        a_ff  <= X_OLD;
        b_ff  <= Y_OLD;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          X_DONE  <= 1'b1;
          FREE_EN <= wr_ff;
          FREE_A  <= a_ff;
          FREE_B  <= b_ff;
        end
      end
    end
  end
endmodule : dpr_retire_model

//--- test_dual_pipe_rename_forward.sv
// bench for the rename and forward block, one reset per scenario
// assumes dpr_pkg and the retire model are compiled first
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_dual_pipe_rename_forward;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RSTN = 0, SAME_ADDR = 0, CACHEABLE = 0;
  dpr_pkg::dpr_inst_t  PX = '0, PY = '0;
  dpr_pkg::dpr_issue_t ISSUE, iss;
  dpr_pkg::dpr_phys_t  X_OLD, Y_OLD, FREE_A, FREE_B, xo, yo;
  logic [1:0] FREE_EN;
  logic X_DONE, PAIR_READY, Y_STALL, Y_COMMIT_OK, st, cok, rdy;
  int n_errors = 0, num_checks = 0;
  always #5 CLK = ~CLK;
  dpr_rename uut (.CLK(CLK), .RSTN(RSTN), .PAIR_X(PX), .PAIR_Y(PY),
    .SAME_ADDR(SAME_ADDR), .CACHEABLE(CACHEABLE), .X_DONE(X_DONE),
    .FREE_EN(FREE_EN), .FREE_A(FREE_A), .FREE_B(FREE_B),
    .PAIR_READY(PAIR_READY), .ISSUE(ISSUE), .X_OLD(X_OLD), .Y_OLD(Y_OLD),
    .Y_STALL(Y_STALL), .Y_COMMIT_OK(Y_COMMIT_OK));
  dpr_retire_model rm (.CLK(CLK), .RSTN(RSTN), .ISSUE_V(ISSUE.valid),
    .X_WR(PX.wr), .Y_WR(PY.wr), .X_OLD(X_OLD), .Y_OLD(Y_OLD),
    .X_DONE(X_DONE), .FREE_EN(FREE_EN), .FREE_A(FREE_A), .FREE_B(FREE_B));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  function automatic dpr_pkg::dpr_inst_t mk(logic ra, logic [2:0] sa,
      logic rb, logic [2:0] sb, logic w, logic [2:0] d, logic mv,
      logic mr, logic mw, logic [1:0] sz);
    return {1'b1, ra, sa, rb, sb, w, d, mv, mr, mw, sz};
  endfunction : mk
  task automatic rst;
    RSTN = 0;
    repeat (8) @(posedge CLK);
    #1 RSTN = 1;
    `CHK("ready", 1'h1, PAIR_READY)
    `CHK("commit", 1'h1, Y_COMMIT_OK)
  endtask : rst
  // offer a pair, wait for its renamed issue
  task automatic offer(dpr_pkg::dpr_inst_t x, dpr_pkg::dpr_inst_t y);
    PX = x;
    PY = y;
    @(posedge CLK);
    #1 PX.valid = 0;
    PY.valid = 0;
    for (int i = 0; i < 4 && ISSUE.valid !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    iss = ISSUE;
    xo = X_OLD;
    yo = Y_OLD;
    st = Y_STALL;
    cok = Y_COMMIT_OK;
    rdy = PAIR_READY;
    `CHK("valid", 1'h1, iss.valid)
  endtask : offer
  task automatic t_war;
    rst();
    offer(mk(1,0,0,0,1,1,1,0,0,2), mk(1,0,1,2,1,0,0,0,0,2));
    `CHK("x_dst", 5'h08, iss.x_dst)
    `CHK("y_dst", 5'h09, iss.y_dst)
    `CHK("y_a", 5'h00, iss.y_a)
    `CHK("y_b", 5'h02, iss.y_b)
    `CHK("ready", 1'h1, rdy)
    `CHK("x_old", 5'h01, xo)
    `CHK("y_old", 5'h00, yo)
    `CHK("stall", 1'h0, st)
    $display("war done");
  endtask : t_war
  task automatic t_waw;
    rst();
    offer(mk(1,0,1,1,1,0,0,0,0,2), mk(0,0,0,0,1,0,1,1,0,2));
    `CHK("y_dst", 5'h09, iss.y_dst)
    `CHK("stall", 1'h0, st)
    repeat (6) @(posedge CLK);
    #1 offer(mk(1,0,0,0,1,3,1,0,0,2), '0);
    `CHK("x_a", 5'h09, iss.x_a)
    $display("waw done");
  endtask : t_waw
  task automatic t_fwd;
    rst();
    offer(mk(1,1,0,0,1,0,1,0,0,2), mk(1,0,1,2,1,2,0,0,0,2));
    `CHK("y_a", 5'h01, iss.y_a)
    `CHK("ilk", 1'h0, iss.interlock)
    rst();
    offer(mk(0,0,0,0,1,0,1,1,0,2), mk(1,0,1,1,1,1,0,0,0,2));
    `CHK("opnd", 1'h1, iss.opnd_fwd)
    rst();
    offer(mk(0,0,0,0,1,0,1,1,0,2), mk(1,0,1,1,1,1,0,0,0,1));
    `CHK("opnd", 1'h0, iss.opnd_fwd)
    `CHK("ilk", 1'h1, iss.interlock)
    rst();
    offer(mk(1,0,1,1,1,0,0,0,0,2), mk(1,0,0,0,0,0,1,0,1,2));
    `CHK("rslt", 1'h1, iss.rslt_fwd)
    `CHK("stall", 1'h0, st)
    $display("forward done");
  endtask : t_fwd
  task automatic t_byp(logic c);
    rst();
    SAME_ADDR = 1;
    CACHEABLE = c;
    offer(mk(1,0,0,0,0,0,0,1,1,2), mk(1,1,0,0,1,1,0,1,0,2));
    SAME_ADDR = 0;
    `CHK("bypass", c, iss.bypass)
    `CHK("stall", 1'h1, st)
    `CHK("commit", 1'h0, cok)
    `CHK("ready", 1'h0, rdy)
    for (int i = 0; i < (c ? 1 : 10) && Y_STALL !== 1'b0; i++) begin
      @(posedge CLK);
      #1;
    end
    `CHK("stall", 1'h0, Y_STALL)
    `CHK("ready", 1'h1, PAIR_READY)
    `CHK("commit", !c, Y_COMMIT_OK)
    $display("bypass done");
  endtask : t_byp
  // 24 spare registers after reset, two taken per pair
  task automatic t_pool;
    rst();
    for (int i = 0; i < 12; i++) begin
      offer(mk(0,0,0,0,1,0,0,0,0,2), mk(0,0,0,0,1,1,0,0,0,2));
      `CHK("ready", i < 11, rdy)
      @(posedge CLK);
      #1;
    end
    `CHK("x_dst", 5'h1e, iss.x_dst)
    `CHK("y_dst", 5'h1f, iss.y_dst)
    repeat (8) @(posedge CLK);
    #1;
    `CHK("ready", 1'h1, PAIR_READY)
    $display("pool done");
  endtask : t_pool
  initial begin
    t_war();
    t_waw();
    t_fwd();
    t_pool();
    t_byp(1);
    t_byp(0);
    conclude();
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule : test_dual_pipe_rename_forward
